// ### rtl/flash_prot_pkg.sv
package flash_prot_pkg;
	// Protection word store
	localparam int NV_WORDS = 7;
	localparam int WORD_W = 16;
	localparam logic [15:0] WORD_ALL_ONES = 16'hffff;
	localparam logic [15:0] WORD_ALL_ZERO = 16'h0000;
	localparam logic [2:0] WI_XLOW = 3'h0;
	localparam logic [2:0] WI_XHIGH = 3'h1;
	localparam logic [2:0] WI_PLOW = 3'h2;
	localparam logic [2:0] WI_PHIGH = 3'h3;
	localparam logic [2:0] WI_APR0 = 3'h4;
	localparam logic [2:0] WI_APR1L = 3'h5;
	localparam logic [2:0] WI_APR1H = 3'h6;
	localparam logic [2:0] WI_LAST = 3'h6;
	// Implemented bits of each word; the rest read as one
	localparam logic [15:0] MASK_XLOW = 16'h8007;
	localparam logic [15:0] MASK_XHIGH = 16'h0003;
	localparam logic [15:0] MASK_PLOW = 16'h03ff;
	localparam logic [15:0] MASK_PHIGH = 16'h0003;
	localparam logic [15:0] MASK_APR0 = 16'h0003;
	localparam logic [15:0] MASK_APR1 = 16'hffff;
	localparam int FREEZE_BIT = 15;
	localparam int DATA_READ_GUARD_BIT = 0;
	localparam int DEBUG_GUARD_BIT = 1;
	localparam logic [3:0] SECT_XB2 = 4'h3;
	localparam logic [3:0] SECT_XB3 = 4'h2;
	localparam logic [3:0] SECT_PB0 = 4'ha;
	localparam logic [3:0] SECT_PB1 = 4'h2;
	// Register indexes; byte address is four times the index
	localparam int AXI_AW = 22;
	localparam logic [19:0] RI_XLOW = 20'hedfb0;
	localparam logic [19:0] RI_XHIGH = 20'hedfb2;
	localparam logic [19:0] RI_PLOW = 20'hedfb4;
	localparam logic [19:0] RI_PHIGH = 20'hedfb6;
	localparam logic [19:0] RI_APR0 = 20'hedfb8;
	localparam logic [19:0] RI_APR1L = 20'hedfbc;
	localparam logic [19:0] RI_APR1H = 20'hedfbe;
	localparam logic [19:0] RI_CTRL = 20'hedfc0;
	localparam logic [19:0] RI_STATUS = 20'hedfc2;
	localparam logic [19:0] RI_MASK = 20'hedfc4;
	localparam int CTRL_PERM_BIT = 0;
	localparam int ST_W = 4;
	localparam int ST_PROT_SECT_ERR = 0;
	localparam int ST_ACCV = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_LOADED = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {SRC_PRIMARY, SRC_XBANK2, SRC_XBANK3, SRC_IRAM, SRC_XRAM, SRC_EXTMEM} src_t;
	typedef enum logic [2:0] {TGT_PBANK0, TGT_PBANK1, TGT_XBANK2, TGT_XBANK3, TGT_NVCELLS, TGT_OTHER} tgt_t;
	typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_PROG} acc_kind_t;
	typedef struct packed {
		logic valid;
		acc_kind_t kind;
		tgt_t tgt;
		logic [3:0] sector;
		src_t src;
		logic debug;
	} acc_req_t;
	typedef struct packed {
		logic done;
		logic ok;
		logic blocked;
		logic dummy;
	} acc_ans_t;
endpackage : flash_prot_pkg

// ### rtl/flash_protection_fuse_logic.sv
// Contract
// - Copy seven protection words once at reset
// - All protections active until copy completes
// - Refuse protection programming from extension bank two
// - Nonvolatile bits only go from one to zero
// - Bank two sector bits block writes
// - Bank three sector bits block writes
// - Primary bank zero sector bits block writes
// - Primary bank one sector bits block writes
// - Freeze bit blocks writes to protection cells
// - Frozen configuration changes only by temporary unprotection
// - Access guard refuses primary data outside flash
// - Erased debug guard lets debug bypass protections
// - Programmed debug guard disables debug entirely
// - Access guard never blocks extension flash
// - Protection words delivered as all ones
// - Protected program or erase sets error flag
// - Guarded primary read from RAM returns dummy
// - Temporary changes revert to nonvolatile values at reset
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_protection_fuse_logic
	import flash_prot_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire src_t prog_src,
	output logic [2:0] nv_rd_idx,
	output logic nv_rd_en,
	input wire logic [15:0] nv_rd_data,
	output logic nv_prog,
	output logic [2:0] nv_prog_idx,
	output logic [15:0] nv_prog_data,
	input wire acc_req_t acc_req,
	output acc_ans_t acc_ans,
	output logic debug_enable,
	output logic irq
);
	typedef enum logic {LD_RUN, LD_DONE} ld_state_t;

	// Implemented-bit mask of one protection word
	function automatic logic [15:0] word_mask(input logic [2:0] idx);
		unique case (idx)
			WI_XLOW: word_mask = MASK_XLOW;
			WI_XHIGH: word_mask = MASK_XHIGH;
			WI_PLOW: word_mask = MASK_PLOW;
			WI_PHIGH: word_mask = MASK_PHIGH;
			WI_APR0: word_mask = MASK_APR0;
			default: word_mask = MASK_APR1;
		endcase
	endfunction : word_mask

	// Maps a byte address to a protection word; bit 3 flags a hit
	function automatic logic [3:0] word_sel(input logic [AXI_AW-1:0] addr);
		logic [19:0] ri;
		ri = addr[AXI_AW-1:2];
		if (ri == RI_XLOW) word_sel = {1'b1, WI_XLOW};
		else if (ri == RI_XHIGH) word_sel = {1'b1, WI_XHIGH};
		else if (ri == RI_PLOW) word_sel = {1'b1, WI_PLOW};
		else if (ri == RI_PHIGH) word_sel = {1'b1, WI_PHIGH};
		else if (ri == RI_APR0) word_sel = {1'b1, WI_APR0};
		else if (ri == RI_APR1L) word_sel = {1'b1, WI_APR1L};
		else if (ri == RI_APR1H) word_sel = {1'b1, WI_APR1H};
		else word_sel = 4'h0;
	endfunction : word_sel

	// Sector write permission; an out-of-range sector counts as protected
	function automatic logic sector_writable(input logic [NV_WORDS-1:0][15:0] w, input tgt_t tgt,
			input logic [3:0] s);
		unique case (tgt)
			TGT_XBANK2: sector_writable = (s < SECT_XB2) && w[WI_XLOW][s];
			TGT_XBANK3: sector_writable = (s < SECT_XB3) && w[WI_XHIGH][s];
			TGT_PBANK0: sector_writable = (s < SECT_PB0) && w[WI_PLOW][s];
			TGT_PBANK1: sector_writable = (s < SECT_PB1) && w[WI_PHIGH][s];
			TGT_NVCELLS: sector_writable = w[WI_XLOW][FREEZE_BIT];
			default: sector_writable = 1'b1;
		endcase
	endfunction : sector_writable

	function automatic logic from_flash(input src_t s);
		from_flash = (s == SRC_PRIMARY) || (s == SRC_XBANK2) || (s == SRC_XBANK3);
	endfunction : from_flash

	ld_state_t ld_state_r;
	logic [NV_WORDS-1:0][15:0] vol_r;
	logic [NV_WORDS-1:0][15:0] shadow_r;
	logic [NV_WORDS-1:0][15:0] eff;
	logic loaded;
	logic aw_held_r, w_held_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic perm_r;
	logic [ST_W-1:0] status_r, mask_r, st_set;
	logic wr_fire, wr_hit, wr_refused, wr_is_ctrl, wr_is_status, wr_is_mask;
	logic [2:0] wr_idx;
	logic [15:0] wr_word, vol_nxt;
	logic [3:0] rd_sel;
	logic [19:0] rd_ri;
	logic acc_ok_nxt, acc_block_nxt, acc_dummy_nxt;

	assign loaded = (ld_state_r == LD_DONE);

	// Before the copy ends every guard bit is seen as programmed
	always_comb begin
		for (int i = 0; i < NV_WORDS; i++) begin
			eff[i] = loaded ? vol_r[i] : WORD_ALL_ZERO;
		end
	end

	// Single pass over the cells after reset; never repeated until the next reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ld_state_r <= LD_RUN;
			nv_rd_idx <= WI_XLOW;
			nv_rd_en <= 1'b1;
		end else begin
			unique case (ld_state_r)
				LD_RUN: begin
					if (nv_rd_idx == WI_LAST) begin
						ld_state_r <= LD_DONE;
						nv_rd_en <= 1'b0;
					end else begin
						nv_rd_idx <= nv_rd_idx + 3'h1;
					end
				end
				LD_DONE: nv_rd_en <= 1'b0;
			endcase
		end
	end

	// Write decode and refusal of the protection-programming operation
	always_comb begin
		wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
		{wr_hit, wr_idx} = word_sel(awaddr_r);
		wr_is_ctrl = (awaddr_r[AXI_AW-1:2] == RI_CTRL);
		wr_is_status = (awaddr_r[AXI_AW-1:2] == RI_STATUS);
		wr_is_mask = (awaddr_r[AXI_AW-1:2] == RI_MASK);
		wr_word = wdata_r[15:0] | ~word_mask(wr_idx);
		wr_refused = wr_hit && (!loaded || prog_src == SRC_XBANK2
			|| (perm_r && !vol_r[WI_XLOW][FREEZE_BIT]));
		if (perm_r) begin
			vol_nxt = shadow_r[wr_idx] & wr_word;
		end else begin
			vol_nxt = wr_word;
			if (wr_idx == WI_APR0 && !from_flash(prog_src)) begin
				vol_nxt[DATA_READ_GUARD_BIT] = vol_r[WI_APR0][DATA_READ_GUARD_BIT] & wr_word[DATA_READ_GUARD_BIT];
			end
		end
	end

	// Volatile and nonvolatile images; reset restores delivery state then reloads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vol_r <= {NV_WORDS{WORD_ALL_ONES}};
			shadow_r <= {NV_WORDS{WORD_ALL_ONES}};
			nv_prog <= 1'b0;
			nv_prog_idx <= WI_XLOW;
			nv_prog_data <= WORD_ALL_ONES;
		end else begin
			nv_prog <= 1'b0;
			if (ld_state_r == LD_RUN) begin
				vol_r[nv_rd_idx] <= nv_rd_data | ~word_mask(nv_rd_idx);
				shadow_r[nv_rd_idx] <= nv_rd_data | ~word_mask(nv_rd_idx);
			end else if (wr_fire && wr_hit && !wr_refused) begin
				vol_r[wr_idx] <= vol_nxt;
				if (perm_r) begin
					shadow_r[wr_idx] <= vol_nxt;
					nv_prog <= 1'b1;
					nv_prog_idx <= wr_idx;
					nv_prog_data <= vol_nxt;
				end
			end
		end
	end

	// Access checker: one registered answer per request
	always_comb begin
		acc_ok_nxt = 1'b1;
		acc_dummy_nxt = 1'b0;
		if (acc_req.debug) begin
			acc_ok_nxt = eff[WI_APR0][DEBUG_GUARD_BIT];
		end else if (acc_req.kind == ACC_PROG) begin
			acc_ok_nxt = sector_writable(eff, acc_req.tgt, acc_req.sector);
		end else if ((acc_req.tgt == TGT_PBANK0 || acc_req.tgt == TGT_PBANK1)
				&& !eff[WI_APR0][DATA_READ_GUARD_BIT] && !from_flash(acc_req.src)) begin
			acc_ok_nxt = 1'b0;
			acc_dummy_nxt = (acc_req.kind == ACC_READ);
		end
		// Nothing is granted while the copy runs, even unguarded targets
		if (!loaded) begin
			acc_ok_nxt = 1'b0;
		end
		acc_block_nxt = !acc_ok_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_ans <= '0;
		end else begin
			acc_ans.done <= acc_req.valid;
			acc_ans.ok <= acc_req.valid && acc_ok_nxt;
			acc_ans.blocked <= acc_req.valid && acc_block_nxt;
			acc_ans.dummy <= acc_req.valid && acc_dummy_nxt;
		end
	end

	// Debug port stays off until the guard bit is known to be erased
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			debug_enable <= 1'b0;
		end else begin
			debug_enable <= eff[WI_APR0][DEBUG_GUARD_BIT];
		end
	end

	// Sticky events; a new event beats a same-cycle write-one clear
	always_comb begin
		st_set = '0;
		st_set[ST_PROT_SECT_ERR] = acc_req.valid && !acc_req.debug && acc_req.kind == ACC_PROG && acc_block_nxt;
		st_set[ST_ACCV] = acc_req.valid && !acc_req.debug && acc_req.kind != ACC_PROG && acc_block_nxt;
		st_set[ST_REFUSED] = wr_fire && wr_refused;
		st_set[ST_LOADED] = (ld_state_r == LD_RUN) && (nv_rd_idx == WI_LAST);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= '0;
			mask_r <= '0;
			perm_r <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr_fire && wr_is_status && wstrb_r[0]) begin
				status_r <= (status_r & ~wdata_r[ST_W-1:0]) | st_set;
			end else begin
				status_r <= status_r | st_set;
			end
			if (wr_fire && wr_is_mask && wstrb_r[0]) begin
				mask_r <= wdata_r[ST_W-1:0];
			end
			if (wr_fire && wr_is_ctrl && wstrb_r[0]) begin
				perm_r <= wdata_r[CTRL_PERM_BIT];
			end
			irq <= |((status_r | st_set) & mask_r);
		end
	end

	// AXI write channels: address and data held independently, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_refused || !(wr_hit || wr_is_ctrl || wr_is_status || wr_is_mask))
					? RESP_SLVERR : RESP_OKAY;
			end
			// Ready returns only after the response is taken, so at most one write is open
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI read: answer one cycle after the address is taken
	always_comb begin
		rd_sel = word_sel(s_axi_araddr);
		rd_ri = s_axi_araddr[AXI_AW-1:2];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				if (rd_sel[3]) begin
					s_axi_rdata <= {16'h0000, vol_r[rd_sel[2:0]]};
				end else if (rd_ri == RI_CTRL) begin
					s_axi_rdata <= {31'h0, perm_r};
				end else if (rd_ri == RI_STATUS) begin
					s_axi_rdata <= {28'h0, status_r};
				end else if (rd_ri == RI_MASK) begin
					s_axi_rdata <= {28'h0, mask_r};
				end else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_NO_GRANT_BEFORE_LOAD: assert property (!loaded && acc_req.valid |=> !acc_ans.ok)
		else $error("access granted before protection load");
	AST_LOAD_ONCE: assert property (loaded |=> loaded && !nv_rd_en)
		else $error("protection load repeated");
	AST_LOAD_LEN: assert property ($rose(aresetn) |-> ##7 loaded)
		else $error("protection load not done in seven cycles");
	AST_B2_REFUSED: assert property (wr_fire && wr_hit && prog_src == SRC_XBANK2 |=>
		s_axi_bresp == RESP_SLVERR && status_r[ST_REFUSED])
		else $error("programming from bank two accepted");
	AST_OTP: assert property (nv_prog |-> (nv_prog_data & ~$past(shadow_r[wr_idx])) == 16'h0000)
		else $error("nonvolatile bit restored to one");
	AST_WRITE_GUARD: assert property (acc_req.valid && !acc_req.debug && acc_req.kind == ACC_PROG
		&& loaded && acc_req.tgt == TGT_PBANK0 && acc_req.sector < SECT_PB0
		&& !vol_r[WI_PLOW][acc_req.sector] |=> acc_ans.blocked && status_r[ST_PROT_SECT_ERR])
		else $error("protected sector write not blocked");
	AST_FREEZE: assert property (wr_fire && wr_hit && perm_r && !vol_r[WI_XLOW][FREEZE_BIT] |=>
		!nv_prog)
		else $error("frozen cells programmed");
	AST_ACCESS_GUARD: assert property (acc_req.valid && !acc_req.debug && acc_req.kind == ACC_READ
		&& acc_req.tgt == TGT_PBANK1 && acc_req.src == SRC_IRAM && !eff[WI_APR0][DATA_READ_GUARD_BIT]
		|=> acc_ans.blocked && acc_ans.dummy)
		else $error("guarded primary read not replaced by dummy");
	AST_EXT_OPEN: assert property (acc_req.valid && !acc_req.debug && acc_req.kind != ACC_PROG
		&& loaded && acc_req.tgt == TGT_XBANK2 |=> acc_ans.ok)
		else $error("extension flash access blocked");
	AST_DEBUG_OFF: assert property (loaded && !vol_r[WI_APR0][DEBUG_GUARD_BIT] |=> !debug_enable)
		else $error("debug enabled while guarded");
	AST_IRQ: assert property (status_r[ST_PROT_SECT_ERR] && mask_r[ST_PROT_SECT_ERR] |=> irq)
		else $error("interrupt missing");

	COV_LOAD: cover property ($rose(loaded));
	COV_WP_BLOCK: cover property (acc_ans.blocked && !acc_ans.dummy);
	COV_DUMMY: cover property (acc_ans.dummy);
	COV_PERM_PROG: cover property (nv_prog);
endmodule : flash_protection_fuse_logic
`default_nettype wire

// ### test/nv_cell_model.sv
`timescale 1ns/1ps
`default_nettype none
module nv_cell_model
	import flash_prot_pkg::*;
(
	input wire logic aclk,
	input wire logic [2:0] nv_rd_idx,
	input wire logic nv_rd_en,
	output logic [15:0] nv_rd_data,
	input wire logic nv_prog,
	input wire logic [2:0] nv_prog_idx,
	input wire logic [15:0] nv_prog_data
);
	// Cells leave the factory erased
	logic [15:0] cell_r [NV_WORDS] = '{default: WORD_ALL_ONES};
	logic [15:0] last_r = WORD_ALL_ONES;
	// Programming only clears bits; an erased state never comes back
	always_ff @(posedge aclk) begin
		if (nv_prog && nv_prog_idx <= WI_LAST) begin
			cell_r[nv_prog_idx] <= cell_r[nv_prog_idx] & nv_prog_data;
		end
		last_r <= nv_rd_data;
	end
	// Outside a load the bus toggles, so a stale word cannot pass as valid
	assign nv_rd_data = (nv_rd_en && nv_rd_idx <= WI_LAST) ? cell_r[nv_rd_idx] : ~last_r;
endmodule : nv_cell_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import flash_prot_pkg::*;
;
	typedef struct packed {acc_kind_t kind; tgt_t tgt; logic [3:0] sec; src_t src; logic dbg; logic [3:0] exp;} row_t;
	// Answer codes: done ok blocked dummy
	localparam row_t ROWS [19] = '{
		'{ACC_PROG, TGT_XBANK2, 4'h0, SRC_IRAM, 1'b0, 4'ha}, '{ACC_PROG, TGT_XBANK2, 4'h1, SRC_IRAM, 1'b0, 4'hc},
		'{ACC_PROG, TGT_XBANK2, 4'h3, SRC_IRAM, 1'b0, 4'ha}, '{ACC_PROG, TGT_XBANK3, 4'h0, SRC_IRAM, 1'b0, 4'ha},
		'{ACC_PROG, TGT_XBANK3, 4'h1, SRC_IRAM, 1'b0, 4'hc}, '{ACC_PROG, TGT_PBANK0, 4'h0, SRC_IRAM, 1'b0, 4'ha},
		'{ACC_PROG, TGT_PBANK0, 4'h9, SRC_IRAM, 1'b0, 4'hc}, '{ACC_PROG, TGT_PBANK0, 4'ha, SRC_IRAM, 1'b0, 4'ha},
		'{ACC_PROG, TGT_PBANK1, 4'h0, SRC_IRAM, 1'b0, 4'ha}, '{ACC_PROG, TGT_PBANK1, 4'h1, SRC_IRAM, 1'b0, 4'hc},
		'{ACC_PROG, TGT_OTHER, 4'h0, SRC_IRAM, 1'b0, 4'hc}, '{ACC_PROG, TGT_NVCELLS, 4'h0, SRC_IRAM, 1'b0, 4'hc},
		'{ACC_READ, TGT_PBANK0, 4'h0, SRC_IRAM, 1'b0, 4'hb}, '{ACC_WRITE, TGT_PBANK1, 4'h1, SRC_XRAM, 1'b0, 4'ha},
		'{ACC_READ, TGT_PBANK0, 4'h0, SRC_PRIMARY, 1'b0, 4'hc}, '{ACC_READ, TGT_PBANK0, 4'h0, SRC_XBANK3, 1'b0, 4'hc},
		'{ACC_READ, TGT_XBANK2, 4'h0, SRC_IRAM, 1'b0, 4'hc}, '{ACC_WRITE, TGT_XBANK3, 4'h1, SRC_EXTMEM, 1'b0, 4'hc},
		'{ACC_PROG, TGT_PBANK0, 4'h0, SRC_IRAM, 1'b1, 4'hc}
	};
	localparam logic [19:0] REGS [5] = '{RI_XLOW, RI_XHIGH, RI_PLOW, RI_PHIGH, RI_APR0};
	localparam logic [15:0] WDAT [5] = '{16'hfffe, 16'h0002, 16'hfffe, 16'hfffe, 16'hfffe};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [AXI_AW-1:0] awaddr = '0;
	logic [AXI_AW-1:0] araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, nv_rd_en, nv_prog, debug_enable, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [2:0] nv_rd_idx, nv_prog_idx;
	logic [15:0] nv_rd_data, nv_prog_data;
	src_t prog_src = SRC_PRIMARY;
	acc_req_t acc_req = '0;
	acc_ans_t acc_ans;
	int comparisons = 0, n_mismatch = 0, n_prog = 0;
	flash_protection_fuse_logic flash_protection_fuse_logic_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .prog_src(prog_src), .nv_rd_idx(nv_rd_idx), .nv_rd_en(nv_rd_en),
		.nv_rd_data(nv_rd_data), .nv_prog(nv_prog), .nv_prog_idx(nv_prog_idx), .nv_prog_data(nv_prog_data),
		.acc_req(acc_req), .acc_ans(acc_ans), .debug_enable(debug_enable), .irq(irq));
	nv_cell_model nv_cell_model_i (.aclk(aclk), .nv_rd_idx(nv_rd_idx), .nv_rd_en(nv_rd_en),
		.nv_rd_data(nv_rd_data), .nv_prog(nv_prog), .nv_prog_idx(nv_prog_idx), .nv_prog_data(nv_prog_data));
	always #5 aclk = ~aclk;
	// Count programming pulses seen on the cell side
	always @(posedge aclk) if (nv_prog === 1'b1) n_prog <= n_prog + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [19:0] idx, input logic [15:0] d);
		int i;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (i == 50) begin
			check(i, 0);
			report_and_stop();
		end
	endtask : wr
	task automatic rdreg(input logic [19:0] idx);
		int i;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (i == 50) begin
			check(i, 0);
			report_and_stop();
		end
	endtask : rdreg
	// One request, answer sampled in its single cycle
	task automatic acc(input acc_kind_t kind, input tgt_t tgt, input logic [3:0] sec, input src_t src,
		input logic dbg, input logic [3:0] exp);
		@(posedge aclk);
		acc_req <= '{1'b1, kind, tgt, sec, src, dbg};
		@(posedge aclk);
		acc_req.valid <= 1'b0;
		#1;
		check({28'h0, acc_ans}, {28'h0, exp});
	endtask : acc
	// Probe during the load window, then wait for the load to finish
	task automatic rst();
		int i;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		acc(ACC_PROG, TGT_OTHER, 4'h0, SRC_PRIMARY, 1'b0, 4'ha);
		for (i = 0; i < 20; i++) begin
			rdreg(RI_STATUS);
			if (rd[ST_LOADED] === 1'b1) break;
		end
		check(i < 20, 1'b1);
	endtask : rst
	initial begin
		int k;
		rst();
		for (k = 0; k < 5; k++) begin
			rdreg(REGS[k]);
			check(rd, 32'hffff);
		end
		rdreg(RI_MASK);
		check(rd, 32'h0);
		rdreg(20'h00010);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		check(debug_enable, 1'b1);
		$display("test reset values done");
		for (k = 0; k < 5; k++) begin
			wr(REGS[k], WDAT[k]);
			rdreg(REGS[k]);
			check(rd, 32'hfffe);
		end
		for (k = 0; k < 19; k++) acc(ROWS[k].kind, ROWS[k].tgt, ROWS[k].sec, ROWS[k].src, ROWS[k].dbg, ROWS[k].exp);
		rdreg(RI_STATUS);
		check(rd[1:0], 2'h3);
		$display("test access table done");
		wr(RI_STATUS, 16'h000f);
		wr(RI_MASK, 16'h0001);
		acc(ACC_PROG, TGT_XBANK2, 4'h0, SRC_IRAM, 1'b0, 4'ha);
		repeat (2) @(posedge aclk);
		check(irq, 1'b1);
		wr(RI_MASK, 16'h0000);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		wr(RI_STATUS, 16'h0001);
		wr(RI_MASK, 16'h0001);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		$display("test interrupt done");
		prog_src <= SRC_XBANK2;
		wr(RI_XHIGH, 16'hffff);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		rdreg(RI_XHIGH);
		check(rd, 32'hfffe);
		prog_src <= SRC_PRIMARY;
		wr(RI_CTRL, 16'h0001);
		k = n_prog;
		wr(RI_PHIGH, 16'hfffd);
		repeat (2) @(posedge aclk);
		check(n_prog - k, 1);
		wr(RI_PHIGH, 16'hffff);
		rdreg(RI_PHIGH);
		check(rd, 32'hfffd);
		wr(RI_APR0, 16'hfffd);
		wr(RI_XLOW, 16'h7fff);
		wr(RI_XHIGH, 16'hfffe);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		$display("test permanent done");
		rst();
		rdreg(RI_XLOW);
		check(rd, 32'h7fff);
		rdreg(RI_PLOW);
		check(rd, 32'hffff);
		rdreg(RI_PHIGH);
		check(rd, 32'hfffd);
		check(debug_enable, 1'b0);
		acc(ACC_PROG, TGT_OTHER, 4'h0, SRC_IRAM, 1'b1, 4'ha);
		acc(ACC_PROG, TGT_NVCELLS, 4'h0, SRC_IRAM, 1'b0, 4'ha);
		wr(RI_XHIGH, 16'h0002);
		check({30'h0, resp}, {30'h0, RESP_OKAY});
		acc(ACC_PROG, TGT_XBANK3, 4'h0, SRC_IRAM, 1'b0, 4'ha);
		$display("test after reload done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
